// ### include/ecct_map.vh
// register map, field positions and reset values of the capture/compare timer
// What this block does
// R1 - direction bit 1 makes channel output compare, 0 makes it input capture
// R2 - force bit causes immediate compare action without flag; force register reads zero
// R3 - master mask bit on compare channel drives pin out, direction bits untouched
// R4 - channel 7 compare copies masked master data bits to the port levels
// R5 - channel 7 compare beats channels 0-6; masked pins take master data level
// R6 - counter writes work only in special mode; reads allowed anytime
// R7 - high-then-low back-to-back read returns a coherent 16-bit counter value
// R8 - clearing timer enable stops counter and the divide-by-64 accumulation clock
// R9 - stop-in-wait set halts timer and accumulator in wait mode
// R10 - stop-in-debug set halts timer in debug; event-count accumulator keeps counting
// R11 - fast clear: capture read or compare write clears flag; counter access clears overflow
// R12 - fast clear: accumulator counter access clears both accumulator flags
// R13 - without fast clear, writing 1 to a flag clears it, 0 does nothing
// R14 - action field: 00 disconnect, 01 toggle, 10 low, 11 high
// R15 - compare channel with nonzero action field drives pin regardless of direction
// R16 - software clears channel 7 action and mask bits to use accumulator input
// R17 - edge field: 00 off, 01 rising, 10 falling, 11 either edge
// R18 - capture or compare event sets channel flag; enable bit passes it to request
// R19 - overflow enable set lets overflow flag raise request; clear blocks it
// R20 - counter reset on channel 7 compare; zero holds counter; all ones suppresses overflow
// R21 - prescaler code doubles divisor 1 to 16; codes 101-111 divide by 32
// R22 - new prescaler divisor applies only when all prescaler stages are zero
// R23 - rollover from all ones to zero sets overflow flag; writing 1 clears
// R24 - selected capture edge latches the counter into the channel register pair
// R25 - compare occurs when counter equals the channel register pair
// R26 - pin inputs are synchronised and edge-detected before capture or counting
`ifndef ECCT_MAP_VH
`define ECCT_MAP_VH

// byte addresses
`define ECCT_A_DIR       8'h80
`define ECCT_A_FORCE     8'h81
`define ECCT_A_MMASK     8'h82
`define ECCT_A_MDATA     8'h83
`define ECCT_A_CNT_HI    8'h84
`define ECCT_A_CNT_LO    8'h85
`define ECCT_A_SYSCTL    8'h86
`define ECCT_A_ACT1      8'h88
`define ECCT_A_ACT2      8'h89
`define ECCT_A_EDGE3     8'h8a
`define ECCT_A_EDGE4     8'h8b
`define ECCT_A_MASK1     8'h8c
`define ECCT_A_MASK2     8'h8d
`define ECCT_A_FLG1      8'h8e
`define ECCT_A_FLG2      8'h8f
`define ECCT_A_CHAN_PAGE 4'h9
`define ECCT_A_PACTL     8'ha0
`define ECCT_A_PAFLG     8'ha1
`define ECCT_A_PACNT_HI  8'ha2
`define ECCT_A_PACNT_LO  8'ha3
`define ECCT_A_PDATA     8'hae
`define ECCT_A_PDIR      8'haf

// field positions
`define ECCT_B_TEN    7
`define ECCT_B_SWAI   6
`define ECCT_B_SBCK   5
`define ECCT_B_FFCA   4
`define ECCT_B_TOI    7
`define ECCT_B_COMPARE_RESET_ENABLE   3
`define ECCT_B_TOF    7
`define ECCT_B_PAEN   6
`define ECCT_B_PAMOD  5
`define ECCT_B_PEDGE  4
`define ECCT_B_PAOVI  1
`define ECCT_B_PAII   0
`define ECCT_B_ACCUMULATOR_OVERFLOW_FLAG  1
`define ECCT_B_ACCUMULATOR_INPUT_FLAG   0
`define ECCT_PA_PIN   7

// values
`define ECCT_RST8     8'h00
`define ECCT_RST16    16'h0000
`define ECCT_ONES16   16'hffff
`define ECCT_P_ZERO   6'h00
`define ECCT_P_FULL   6'h3f
`define ECCT_P_MAXSEL 3'h5
`define ECCT_ACT_OFF  2'b00
`define ECCT_ACT_TOG  2'b01
`define ECCT_ACT_LOW  2'b10
`define ECCT_ACT_HIGH 2'b11
`define ECCT_EDG_RISE 2'b01
`define ECCT_EDG_FALL 2'b10
`define ECCT_EDG_ANY  2'b11

`endif

// ### logic/ecct_timer.v
// eight-channel capture/compare timer with prescaler and pulse accumulator
`timescale 1ns/1ns
`default_nettype none
`include "ecct_map.vh"

module ecct_timer #(
	parameter CH = 8
) (
	// clock and reset
	input  wire         clk,
	input  wire         srst,
	// register port
	input  wire [7:0]   addr,
	input  wire [7:0]   wdata,
	input  wire         wr_stb,
	input  wire         rd_stb,
	output reg  [7:0]   rdata,
	// processor mode
	input  wire         special_mode,
	input  wire         wait_mode,
	input  wire         debug_mode,
	// timer port pins
	input  wire [CH-1:0] pin_in,
	output reg  [CH-1:0] pin_out,
	output reg  [CH-1:0] pin_oe,
	// interrupt requests
	output reg  [CH-1:0] chan_irq,
	output reg           ovf_irq,
	output reg           pa_irq
);

////////////////////////////////////////////////////////////////////////////////
// state

reg  [7:0]    dir_reg, mmask_reg, mdata_reg, sysctl_reg;
reg  [7:0]    act1_reg, act2_reg, edge3_reg, edge4_reg, mask1_reg, mask2_reg;
reg  [7:0]    pactl_reg, pdata_reg, pdir_reg, hold_reg;
reg  [CH-1:0] chf_reg, level_reg, sync1_reg, sync2_reg, sync3_reg;
reg           tof_reg, accumulator_overflow_flag_reg, accumulator_input_flag_reg, hold_vld_reg;
reg  [15:0]   cnt_reg, pacnt_reg;
reg  [15:0]   chan_reg [0:CH-1];
reg  [5:0]    presc_reg;
reg  [2:0]    psel_reg;

////////////////////////////////////////////////////////////////////////////////
// control decode

wire [15:0] act_all  = {act1_reg, act2_reg};
wire [15:0] edge_all = {edge3_reg, edge4_reg};
wire        ffca     = sysctl_reg[`ECCT_B_FFCA];
wire        compare_reset_enable     = mask2_reg[`ECCT_B_COMPARE_RESET_ENABLE];
wire        in_wait  = wait_mode & sysctl_reg[`ECCT_B_SWAI];

// R8 R9 R10 timer run gate
wire        run = sysctl_reg[`ECCT_B_TEN] & ~in_wait & ~(debug_mode & sysctl_reg[`ECCT_B_SBCK]);

// R9 accumulator wait gate
wire        pa_run = pactl_reg[`ECCT_B_PAEN] & ~in_wait;

wire        ch_page = (addr[7:4] == `ECCT_A_CHAN_PAGE);
wire [2:0]  ch_idx  = addr[3:1];
wire [7:0]  ch_one  = 8'h01 << ch_idx;
wire        cnt_acc = (addr == `ECCT_A_CNT_HI) | (addr == `ECCT_A_CNT_LO);
wire        pa_acc  = (addr == `ECCT_A_PACNT_HI) | (addr == `ECCT_A_PACNT_LO);

////////////////////////////////////////////////////////////////////////////////
// prescaler

// R21 divisor mask, codes above 100 all give 32
reg  [5:0] pmask;
always @* begin
	case (psel_reg)
		3'h0:    pmask = 6'h00;
		3'h1:    pmask = 6'h01;
		3'h2:    pmask = 6'h03;
		3'h3:    pmask = 6'h07;
		3'h4:    pmask = 6'h0f;
		default: pmask = 6'h1f;
	endcase
end

wire tick  = run & ((presc_reg & pmask) == pmask);
// R8 divide-by-64 exists only while the timer runs
wire div64 = run & (presc_reg == `ECCT_P_FULL);

////////////////////////////////////////////////////////////////////////////////
// events

wire [CH-1:0] rise = sync2_reg & ~sync3_reg;
wire [CH-1:0] fall = ~sync2_reg & sync3_reg;
reg  [CH-1:0] cmp, cap, force_hit, drive;
integer i;

always @* begin
	for (i = 0; i < CH; i = i + 1) begin
		// R25 equality compare, sampled on the counter tick
		cmp[i] = tick & dir_reg[i] & (cnt_reg == chan_reg[i]);
		// R17 R1 capture edge selection
		case (edge_all[2*i +: 2])
			`ECCT_EDG_RISE: cap[i] = ~dir_reg[i] & rise[i];
			`ECCT_EDG_FALL: cap[i] = ~dir_reg[i] & fall[i];
			`ECCT_EDG_ANY:  cap[i] = ~dir_reg[i] & (rise[i] | fall[i]);
			default:        cap[i] = 1'b0;
		endcase
		// R2 force acts on compare channels only
		force_hit[i] = wr_stb & (addr == `ECCT_A_FORCE) & wdata[i] & dir_reg[i];
		// R3 R15 compare function takes the pin
		drive[i] = dir_reg[i] & ((act_all[2*i +: 2] != `ECCT_ACT_OFF) | mmask_reg[i]);
	end
end

wire master = cmp[CH-1] | force_hit[CH-1];
// R20 channel 7 compare resets counter
wire rst7   = cmp[CH-1] & compare_reset_enable;
wire tof_set = tick & ~rst7 & (cnt_reg == `ECCT_ONES16);

// accumulator: trailing gate edge and counting edge coincide in both modes
wire pa_in   = sync3_reg[`ECCT_PA_PIN];
wire pedge   = pactl_reg[`ECCT_B_PEDGE];
wire pa_edge = pa_run & (pedge ? rise[`ECCT_PA_PIN] : fall[`ECCT_PA_PIN]);
wire pa_gate = pedge ? ~pa_in : pa_in;
wire pa_inc  = pactl_reg[`ECCT_B_PAMOD] ? (pa_run & div64 & pa_gate) : pa_edge;

////////////////////////////////////////////////////////////////////////////////
// flag clears

reg [CH-1:0] chf_clr;
reg          tof_clr, pa_clr_ovf, pa_clr_if;
always @* begin
	chf_clr    = {CH{1'b0}};
	tof_clr    = 1'b0;
	pa_clr_ovf = 1'b0;
	pa_clr_if  = 1'b0;
	if (!ffca) begin
		// R13 write-one clear
		if (wr_stb && addr == `ECCT_A_FLG1)
			chf_clr = wdata;
		if (wr_stb && addr == `ECCT_A_FLG2)
			tof_clr = wdata[`ECCT_B_TOF];
		if (wr_stb && addr == `ECCT_A_PAFLG) begin
			pa_clr_ovf = wdata[`ECCT_B_ACCUMULATOR_OVERFLOW_FLAG];
			pa_clr_if  = wdata[`ECCT_B_ACCUMULATOR_INPUT_FLAG];
		end
	end else begin
		// R11 fast clear on channel and counter access
		if (ch_page && ((rd_stb && !dir_reg[ch_idx]) || (wr_stb && dir_reg[ch_idx])))
			chf_clr = ch_one;
		tof_clr = (rd_stb | wr_stb) & cnt_acc;
		// R12 fast clear on accumulator counter access
		pa_clr_ovf = (rd_stb | wr_stb) & pa_acc;
		pa_clr_if  = (rd_stb | wr_stb) & pa_acc;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read data

function [7:0] rd_val;
	input [7:0] a;
	begin
		if (a[7:4] == `ECCT_A_CHAN_PAGE)
			rd_val = a[0] ? chan_reg[a[3:1]][7:0] : chan_reg[a[3:1]][15:8];
		else
			case (a)
				`ECCT_A_DIR:      rd_val = dir_reg;
				`ECCT_A_MMASK:    rd_val = mmask_reg;
				`ECCT_A_MDATA:    rd_val = mdata_reg;
				`ECCT_A_CNT_HI:   rd_val = cnt_reg[15:8];
				`ECCT_A_CNT_LO:   rd_val = cnt_reg[7:0];
				`ECCT_A_SYSCTL:   rd_val = sysctl_reg;
				`ECCT_A_ACT1:     rd_val = act1_reg;
				`ECCT_A_ACT2:     rd_val = act2_reg;
				`ECCT_A_EDGE3:    rd_val = edge3_reg;
				`ECCT_A_EDGE4:    rd_val = edge4_reg;
				`ECCT_A_MASK1:    rd_val = mask1_reg;
				`ECCT_A_MASK2:    rd_val = mask2_reg;
				`ECCT_A_FLG1:     rd_val = chf_reg;
				`ECCT_A_FLG2:     rd_val = {tof_reg, 7'h00};
				`ECCT_A_PACTL:    rd_val = pactl_reg;
				`ECCT_A_PAFLG:    rd_val = {6'h00, accumulator_overflow_flag_reg, accumulator_input_flag_reg};
				`ECCT_A_PACNT_HI: rd_val = pacnt_reg[15:8];
				`ECCT_A_PACNT_LO: rd_val = pacnt_reg[7:0];
				`ECCT_A_PDATA:    rd_val = pdata_reg;
				`ECCT_A_PDIR:     rd_val = pdir_reg;
				// force register and unmapped space read as zero
				default:          rd_val = `ECCT_RST8;
			endcase
	end
endfunction

// R7 high-byte read freezes the low byte for a read that follows at once
wire pair_hi = (cnt_acc | pa_acc | ch_page) & ~addr[0];
wire pair_lo = (cnt_acc | pa_acc | ch_page) & addr[0];
wire [7:0] lo_addr = addr | 8'h01;

////////////////////////////////////////////////////////////////////////////////
// registers

always @(posedge clk) begin
	if (srst) begin
		dir_reg      <= `ECCT_RST8;
		mmask_reg    <= `ECCT_RST8;
		mdata_reg    <= `ECCT_RST8;
		sysctl_reg   <= `ECCT_RST8;
		act1_reg     <= `ECCT_RST8;
		act2_reg     <= `ECCT_RST8;
		edge3_reg    <= `ECCT_RST8;
		edge4_reg    <= `ECCT_RST8;
		mask1_reg    <= `ECCT_RST8;
		mask2_reg    <= `ECCT_RST8;
		pactl_reg    <= `ECCT_RST8;
		pdata_reg    <= `ECCT_RST8;
		pdir_reg     <= `ECCT_RST8;
		hold_reg     <= `ECCT_RST8;
		hold_vld_reg <= 1'b0;
		chf_reg      <= {CH{1'b0}};
		level_reg    <= {CH{1'b0}};
		sync1_reg    <= {CH{1'b0}};
		sync2_reg    <= {CH{1'b0}};
		sync3_reg    <= {CH{1'b0}};
		tof_reg      <= 1'b0;
		accumulator_overflow_flag_reg    <= 1'b0;
		accumulator_input_flag_reg     <= 1'b0;
		cnt_reg      <= `ECCT_RST16;
		pacnt_reg    <= `ECCT_RST16;
		presc_reg    <= `ECCT_P_ZERO;
		psel_reg     <= 3'h0;
		rdata        <= `ECCT_RST8;
		pin_out      <= {CH{1'b0}};
		pin_oe       <= {CH{1'b0}};
		chan_irq     <= {CH{1'b0}};
		ovf_irq      <= 1'b0;
		pa_irq       <= 1'b0;
		for (i = 0; i < CH; i = i + 1)
			chan_reg[i] <= `ECCT_RST16;
	end else begin
		// R26 three-stage pin synchroniser
		sync1_reg <= pin_in;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;

		// plain control registers
		if (wr_stb) begin
			case (addr)
				`ECCT_A_DIR:    dir_reg    <= wdata;
				`ECCT_A_MMASK:  mmask_reg  <= wdata;
				`ECCT_A_MDATA:  mdata_reg  <= wdata;
				`ECCT_A_SYSCTL: sysctl_reg <= wdata;
				`ECCT_A_ACT1:   act1_reg   <= wdata;
				`ECCT_A_ACT2:   act2_reg   <= wdata;
				`ECCT_A_EDGE3:  edge3_reg  <= wdata;
				`ECCT_A_EDGE4:  edge4_reg  <= wdata;
				`ECCT_A_MASK1:  mask1_reg  <= wdata;
				`ECCT_A_MASK2:  mask2_reg  <= wdata;
				`ECCT_A_PACTL:  pactl_reg  <= wdata;
				`ECCT_A_PDATA:  pdata_reg  <= wdata;
				`ECCT_A_PDIR:   pdir_reg   <= wdata;
				default:        hold_reg   <= hold_reg;
			endcase
		end

		// R22 divisor switches only at the all-zero point
		presc_reg <= run ? presc_reg + 6'h01 : presc_reg;
		if (presc_reg == `ECCT_P_ZERO)
			psel_reg <= (mask2_reg[2:0] > `ECCT_P_MAXSEL) ? `ECCT_P_MAXSEL : mask2_reg[2:0];

		// R6 counter writes only in special mode
		if (wr_stb && special_mode && addr == `ECCT_A_CNT_HI)
			cnt_reg[15:8] <= wdata;
		else if (wr_stb && special_mode && addr == `ECCT_A_CNT_LO)
			cnt_reg[7:0] <= wdata;
		// R20 reset on channel 7 compare, else count
		else if (tick)
			cnt_reg <= rst7 ? `ECCT_RST16 : cnt_reg + 16'h0001;

		// R23 overflow flag, set wins over clear
		tof_reg <= tof_set | (tof_reg & ~tof_clr);

		for (i = 0; i < CH; i = i + 1) begin
			// R24 capture latch
			if (cap[i])
				chan_reg[i] <= cnt_reg;
			else if (wr_stb && ch_page && ch_idx == i && dir_reg[i]) begin
				if (addr[0])
					chan_reg[i][7:0] <= wdata;
				else
					chan_reg[i][15:8] <= wdata;
			end
			// R5 R4 channel 7 overrides other channels on masked pins
			if (master && mmask_reg[i])
				level_reg[i] <= mdata_reg[i];
			// R14 R2 per-channel pin action
			else if (cmp[i] | force_hit[i]) begin
				case (act_all[2*i +: 2])
					`ECCT_ACT_TOG:  level_reg[i] <= ~level_reg[i];
					`ECCT_ACT_LOW:  level_reg[i] <= 1'b0;
					`ECCT_ACT_HIGH: level_reg[i] <= 1'b1;
					default:        level_reg[i] <= level_reg[i];
				endcase
			end
		end

		// R18 flags from capture and compare, never from force
		chf_reg <= cmp | cap | (chf_reg & ~chf_clr);

		// accumulator counter and flags
		if (wr_stb && addr == `ECCT_A_PACNT_HI)
			pacnt_reg[15:8] <= wdata;
		else if (wr_stb && addr == `ECCT_A_PACNT_LO)
			pacnt_reg[7:0] <= wdata;
		else if (pa_inc)
			pacnt_reg <= pacnt_reg + 16'h0001;
		accumulator_overflow_flag_reg <= (pa_inc & (pacnt_reg == `ECCT_ONES16)) | (accumulator_overflow_flag_reg & ~pa_clr_ovf);
		accumulator_input_flag_reg  <= pa_edge | (accumulator_input_flag_reg & ~pa_clr_if);

		// R7 coherent pair read
		if (rd_stb && pair_lo && hold_vld_reg)
			rdata <= hold_reg;
		else if (rd_stb)
			rdata <= rd_val(addr);
		if (rd_stb && pair_hi)
			hold_reg <= rd_val(lo_addr);
		if (rd_stb | wr_stb)
			hold_vld_reg <= rd_stb & pair_hi;

		// R3 R15 pin ownership; port latch shows only when timer lets go
		pin_out <= (drive & level_reg) | (~drive & pdata_reg);
		pin_oe  <= drive | pdir_reg;

		// R18 R19 request outputs
		chan_irq <= chf_reg & mask1_reg;
		ovf_irq  <= tof_reg & mask2_reg[`ECCT_B_TOI];
		pa_irq   <= (accumulator_overflow_flag_reg & pactl_reg[`ECCT_B_PAOVI]) | (accumulator_input_flag_reg & pactl_reg[`ECCT_B_PAII]);
	end
end

endmodule
`default_nettype wire

// ### verif/ecct_pin_model.sv
// external event sources and loads on the timer port pins
`timescale 1ns/1ns
`default_nettype none
module ecct_pin_model #(
	parameter CH = 8
) (
	// timer side
	input  wire logic [CH-1:0] pin_out,
	input  wire logic [CH-1:0] pin_oe,
	// event sources
	input  wire logic [CH-1:0] ext_lvl,
	// resolved pin level
	output logic      [CH-1:0] pin_in
);
	// driven pins read back, others follow the source; pin 7 never driven by both
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ### verif/ecct_timer_sva.sv
// assertions on the timer's register port, pins and requests
`timescale 1ns/1ns
`default_nettype none
module ecct_timer_chk #(
	parameter CH = 8
) (
	// clock and reset
	input wire logic          clk,
	input wire logic          srst,
	// register port
	input wire logic [7:0]    addr,
	input wire logic [7:0]    wdata,
	input wire logic          wr_stb,
	input wire logic          rd_stb,
	input wire logic [7:0]    rdata,
	// processor mode
	input wire logic          special_mode,
	input wire logic          wait_mode,
	input wire logic          debug_mode,
	// pins and requests
	input wire logic [CH-1:0] pin_in,
	input wire logic [CH-1:0] pin_out,
	input wire logic [CH-1:0] pin_oe,
	input wire logic [CH-1:0] chan_irq,
	input wire logic          ovf_irq,
	input wire logic          pa_irq
);
	default clocking cb @(posedge clk); endclocking
	////////////////////////////////////////////////////////////////////////////////
	property p_rst_quiet;
		srst |=> rdata == 8'h00 && pin_out == '0 && pin_oe == '0 && chan_irq == '0
			&& !ovf_irq && !pa_irq;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
	property p_rd_hold;
		disable iff (srst) !rd_stb |=> $stable(rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
	property p_force_zero;
		disable iff (srst) rd_stb && addr == 8'h81 |=> rdata == 8'h00;
	endproperty
	a_force_zero: assert property (p_force_zero) else $error("force register read nonzero");
	property p_hole_zero;
		disable iff (srst) rd_stb && addr == 8'h87 |=> rdata == 8'h00;
	endproperty
	a_hole_zero: assert property (p_hole_zero) else $error("unmapped read nonzero");
	property p_mdata_back;
		disable iff (srst) (wr_stb && addr == 8'h83 ##1 rd_stb && addr == 8'h83)
			|=> rdata == $past(wdata, 2);
	endproperty
	a_mdata_back: assert property (p_mdata_back) else $error("master data readback wrong");
	property p_ovf_gate;
		disable iff (srst) wr_stb && addr == 8'h8d && !wdata[7] |=> ##1 !ovf_irq;
	endproperty
	a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request while disabled");
	property p_chan_gate;
		disable iff (srst) wr_stb && addr == 8'h8c |=> ##1 (chan_irq & ~$past(wdata, 2)) == '0;
	endproperty
	a_chan_gate: assert property (p_chan_gate) else $error("channel request while disabled");
	property p_pa_gate;
		disable iff (srst) wr_stb && addr == 8'ha0 && wdata[1:0] == 2'b00 |=> ##1 !pa_irq;
	endproperty
	a_pa_gate: assert property (p_pa_gate) else $error("accumulator request while disabled");
	c_capture_read: cover property (disable iff (srst) rd_stb && addr == 8'h94);
	c_ovf_req: cover property (disable iff (srst) ovf_irq);
	c_chan_req: cover property (disable iff (srst) chan_irq != '0);
endmodule
bind ecct_timer ecct_timer_chk #(.CH(CH)) u_ecct_timer_chk (
	.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata(rdata), .special_mode(special_mode), .wait_mode(wait_mode),
	.debug_mode(debug_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.chan_irq(chan_irq), .ovf_irq(ovf_irq), .pa_irq(pa_irq)
);
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk, srst, wr_stb, rd_stb, special_mode, wait_mode, debug_mode;
	logic [7:0]  addr, wdata, rdata, ext_lvl, pin_in, pin_out, pin_oe, chan_irq, rd_val;
	logic        ovf_irq, pa_irq;
	logic [15:0] rd16_val, cnt_snap;
	int          err_total, comparisons;
	logic [7:0]  rst_addr [9] = '{8'h80, 8'h82, 8'h83, 8'h86, 8'h88, 8'h8a, 8'h8c, 8'h8d, 8'h8e};
	ecct_timer #(.CH(8)) u_ecct_timer (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .special_mode(special_mode),
		.wait_mode(wait_mode), .debug_mode(debug_mode), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .chan_irq(chan_irq), .ovf_irq(ovf_irq), .pa_irq(pa_irq));
	ecct_pin_model #(.CH(8)) u_ecct_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_lvl(ext_lvl), .pin_in(pin_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 rd_val = rdata;
	endtask
	// high byte then low byte with no gap, so the low byte comes from the frozen copy
	task automatic rd16(input logic [7:0] a);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		addr <= a + 8'h01;
		#1 rd16_val[15:8] = rdata;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 rd16_val[7:0] = rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(16'(rd_val), 16'(exp));
	endtask
	task automatic results;
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// the tests need about 160 cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		{srst, wr_stb, rd_stb, special_mode, wait_mode, debug_mode} = 6'h20;
		{addr, wdata, ext_lvl} = 24'h000000;
		err_total = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		foreach (rst_addr[i]) rchk(rst_addr[i], 8'h00);
		wr(8'ha0, 8'h00);
		wr(8'h81, 8'hff);
		rchk(8'h81, 8'h00);
		rchk(8'h87, 8'h00);
		wr(8'h83, 8'h5a);
		rchk(8'h83, 8'h5a);
		$display("test register map done");
		special_mode <= 1'b1;
		wr(8'h84, 8'h12);
		wr(8'h85, 8'h34);
		rd16(8'h84);
		chk(rd16_val, 16'h1234);
		special_mode <= 1'b0;
		wr(8'h84, 8'h55);
		rd16(8'h84);
		chk(rd16_val, 16'h1234);
		$display("test counter access done");
		wr(8'h8b, 8'h10);
		wr(8'h8c, 8'h04);
		ext_lvl[2] <= 1'b1;
		repeat (6) @(posedge clk);
		rd16(8'h94);
		chk(rd16_val, 16'h1234);
		rchk(8'h8e, 8'h04);
		chk(16'(chan_irq[2]), 16'h0001);
		wr(8'h8e, 8'h00);
		rchk(8'h8e, 8'h04);
		wr(8'h8e, 8'h04);
		rchk(8'h8e, 8'h00);
		ext_lvl[2] <= 1'b0;
		repeat (6) @(posedge clk);
		rchk(8'h8e, 8'h00);
		$display("test input capture done");
		wr(8'h80, 8'h01);
		wr(8'h90, 8'h12);
		wr(8'h91, 8'h40);
		wr(8'h89, 8'h03);
		repeat (2) @(posedge clk);
		chk(16'(pin_oe[0]), 16'h0001);
		wr(8'h86, 8'h80);
		repeat (30) @(posedge clk);
		wr(8'h86, 8'h00);
		chk(16'(pin_out[0]), 16'h0001);
		rchk(8'h8e, 8'h01);
		$display("test output compare done");
		wr(8'h80, 8'h03);
		wr(8'h89, 8'h07);
		wr(8'h81, 8'h02);
		repeat (3) @(posedge clk);
		chk(16'({pin_oe[1], pin_out[1]}), 16'h0003);
		rchk(8'h8e, 8'h01);
		$display("test forced compare done");
		special_mode <= 1'b1;
		wr(8'h84, 8'hff);
		wr(8'h85, 8'hfe);
		special_mode <= 1'b0;
		wr(8'h8d, 8'h80);
		wr(8'h86, 8'h80);
		repeat (10) @(posedge clk);
		rchk(8'h8f, 8'h80);
		chk(16'(ovf_irq), 16'h0001);
		wr(8'h8d, 8'h00);
		repeat (2) @(posedge clk);
		chk(16'(ovf_irq), 16'h0000);
		wr(8'h8f, 8'h80);
		rchk(8'h8f, 8'h00);
		$display("test overflow done");
		wr(8'h86, 8'ha0);
		debug_mode <= 1'b1;
		rd16(8'h84);
		cnt_snap = rd16_val;
		repeat (5) @(posedge clk);
		rd16(8'h84);
		chk(rd16_val, cnt_snap);
		debug_mode <= 1'b0;
		repeat (5) @(posedge clk);
		rd16(8'h84);
		chk(16'(rd16_val != cnt_snap), 16'h0001);
		$display("test debug stop done");
		wr(8'h86, 8'hc0);
		wr(8'ha0, 8'h51);
		wait_mode <= 1'b1;
		ext_lvl[7] <= 1'b1;
		repeat (6) @(posedge clk);
		rchk(8'ha3, 8'h00);
		ext_lvl[7] <= 1'b0;
		repeat (6) @(posedge clk);
		wait_mode <= 1'b0;
		ext_lvl[7] <= 1'b1;
		repeat (6) @(posedge clk);
		chk(16'(pa_irq), 16'h0001);
		rchk(8'ha1, 8'h01);
		wr(8'h86, 8'h90);
		rd16(8'ha2);
		chk(rd16_val, 16'h0001);
		rchk(8'ha1, 8'h00);
		$display("test wait and accumulator done");
		results();
	end
endmodule
`default_nettype wire
